// File: design/flac_regs.svh
// Register offsets, field positions, reset values and status words of the file/auth block.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
`ifndef FLAC_REGS_SVH
`define FLAC_REGS_SVH

// Register byte offsets
`define FLAC_ADR_CMD 8'h00
`define FLAC_ADR_TGT 8'h04
`define FLAC_ADR_ACC 8'h08
`define FLAC_ADR_TLV 8'h0C
`define FLAC_ADR_CHK 8'h10
`define FLAC_ADR_STAT 8'h14
`define FLAC_ADR_LCS 8'h18
`define FLAC_ADR_SEG 8'h1C

// Target register fields
`define FLAC_TGT_FILE_LSB 0
`define FLAC_TGT_DIR_LSB 4
`define FLAC_TGT_FOUND 8
// Access register fields
`define FLAC_ACC_DEACT_LSB 0
`define FLAC_ACC_ACT_LSB 16
// Check register fields
`define FLAC_CHK_FILE_LSB 0
`define FLAC_CHK_FN_LSB 4
// Status register fields
`define FLAC_STAT_SW_LSB 0
`define FLAC_STAT_FILE_LSB 16
`define FLAC_STAT_DIR_LSB 20
`define FLAC_STAT_FILE_VALID 24
`define FLAC_STAT_MODE_LSB 25
`define FLAC_STAT_ALLOW 29
`define FLAC_STAT_BUSY 31
// Segment register fields
`define FLAC_SEG_OFF_LSB 0
`define FLAC_SEG_LEN_LSB 16

// Selection control codes
`define FLAC_P1_BY_FID 8'h00
`define FLAC_P1_PATH_ROOT 8'h08
`define FLAC_P1_PATH_DIR 8'h09
`define FLAC_P2_NONE 8'h00

// Odd authenticate block types, bits 7..5 of P1
`define FLAC_BLK_FIRST_DATA 3'h4
`define FLAC_BLK_NEXT_DATA 3'h0
`define FLAC_BLK_RETX_DATA 3'h2
`define FLAC_BLK_FIRST_RESP 3'h5
`define FLAC_BLK_NEXT_RESP 3'h1
`define FLAC_BLK_RETX_RESP 3'h3

// Wrapper tags and long length forms
`define FLAC_TAG_STRUCT 8'h73
`define FLAC_TAG_PLAIN 8'h53
`define FLAC_LEN_LONG1 8'h81
`define FLAC_LEN_LONG2 8'h82

// Status words
`define FLAC_SW_NONE 16'h0000
`define FLAC_SW_OK 16'h9000
`define FLAC_SW_DATA_MORE 16'h63F1
`define FLAC_SW_DATA_DONE 16'h62F3
`define FLAC_SW_RESP_MORE 16'h62F1
`define FLAC_SW_SECURITY 16'h6982
`define FLAC_SW_NOT_FOUND 16'h6A82
`define FLAC_SW_WRONG_P 16'h6B00
`define FLAC_SW_SEQUENCE 16'h6985
`define FLAC_SW_WRONG_DATA 16'h6A80
`define FLAC_SW_INVALIDATED 16'h6283
`define FLAC_SW_NO_EF 16'h6986
`define FLAC_SW_WRONG_LEN 16'h6700

// Reset values and limits
`define FLAC_RST_WORD 32'h0000_0000
`define FLAC_RST_FLAGS 16'h0000
`define FLAC_LE_MAX 9'h100

`endif

// File: design/flac_pkg.sv
// Types shared by the file/auth block.
// Assumes flac_regs.svh for all numeric constants.
package flac_pkg;

  typedef enum logic [1:0] {
    flac_op_disable,
    flac_op_reenable,
    flac_op_auth_even,
    flac_op_auth_odd
  } flac_op_t;

  typedef enum logic [1:0] {
    flac_sel_current,
    flac_sel_fid,
    flac_sel_root_path,
    flac_sel_dir_path
  } flac_sel_t;

  typedef enum logic [1:0] {
    flac_fn_select,
    flac_fn_reenable,
    flac_fn_other,
    flac_fn_other2
  } flac_fn_t;

  typedef enum logic [1:0] {
    flac_auth_idle,
    flac_auth_rx,
    flac_auth_calc,
    flac_auth_tx
  } flac_auth_t;

  // Command register image
  typedef struct packed {
    logic [4:0] pad;
    flac_op_t op;
    logic data_present;
    logic [7:0] lc;
    logic [7:0] p2;
    logic [7:0] p1;
  } flac_cmd_t;

  // Wrapper header of a first data block
  typedef struct packed {
    logic [7:0] len2;
    logic [7:0] len1;
    logic [7:0] len0;
    logic [7:0] tag;
  } flac_tlv_t;

endpackage : flac_pkg

// File: design/flac_core.sv
// File lifecycle and chained authenticate command handler, Wishbone slave.
// Assumes software resolves file ids and paths into the target register and
// an outside engine computes the authentication response on request.
// Operation
// [RULE_01] Disable command sets file deactivated flag
// [RULE_02] Disable only if disable access granted
// [RULE_03] Successful file command sets current file
// [RULE_04] Failed file command keeps current pointers
// [RULE_05] Deactivated file allows only select, reenable
// [RULE_06] P1 decode: fid, root path, directory path
// [RULE_07] Terminal sends P2 zero, no Le
// [RULE_08] P1 P2 zero, no data: current file
// [RULE_09] Reenable clears flag when access granted
// [RULE_10] Reenable uses same selection coding
// [RULE_11] Terminal selects application before authenticate
// [RULE_12] Even instruction for short plain challenge
// [RULE_13] Odd instruction carries wrapped data, optional
// [RULE_14] Wrapper tag 73 structured, 53 otherwise
// [RULE_15] Chained blocks, 255 bytes, P1 first/next
// [RULE_16] Terminal segments data, flags first/next
// [RULE_17] Outstanding data blocks answered 63F1
// [RULE_18] All data received: compute, answer 62F3
// [RULE_19] Response fetched in first/next blocks
// [RULE_20] More response segments pending: 62F1
// [RULE_21] Final response segment answered 9000
// [RULE_22] Retransmit repeats previous block
// [RULE_23] P1 bits 7..5 give block type
// [RULE_24] Data blocks Lc only, response Le only
// [RULE_25] Orphan next/retransmit refused, state kept
`include "flac_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module flac_core (
  input wire logic i_core_clk, // 250 MHz clock
  input wire logic i_rst_b, // Async reset, active low
  input wire logic i_wb_cyc, // Bus cycle
  input wire logic i_wb_stb, // Bus strobe
  input wire logic i_wb_we, // Write enable
  input wire logic [7:0] i_wb_adr, // Byte address
  input wire logic [3:0] i_wb_sel, // Byte selects
  input wire logic [31:0] i_wb_dat, // Write data
  input wire logic i_calc_done, // Engine finished
  input wire logic [15:0] i_calc_len, // Response length from engine
  output logic [31:0] o_wb_dat, // Read data
  output logic o_wb_ack, // Bus acknowledge
  output logic o_calc_req, // Start engine, one cycle
  output logic [16:0] o_calc_len // Challenge length for engine
);

  logic req;
  logic wr;
  logic cmd_go;
  flac_pkg::flac_cmd_t cmd;
  flac_pkg::flac_tlv_t tlv;
  logic [2:0] blk;
  logic [15:0] lcs_q;
  logic [15:0] acc_deact_q;
  logic [15:0] acc_act_q;
  logic [3:0] tgt_file_q;
  logic [3:0] tgt_dir_q;
  logic tgt_found_q;
  logic [31:0] tlv_q;
  logic [3:0] cur_file_q;
  logic [3:0] cur_dir_q;
  logic cur_valid_q;
  flac_pkg::flac_sel_t mode_q;
  flac_pkg::flac_sel_t f_mode;
  logic allow_q;
  logic [15:0] sw_q;
  logic [15:0] f_sw;
  logic f_ok;
  logic [3:0] f_idx;
  logic [3:0] f_dir;
  flac_pkg::flac_auth_t auth_q;
  flac_pkg::flac_auth_t auth_d;
  logic even_q;
  logic rx_act_q;
  logic rx_act_d;
  logic [16:0] rx_total_q;
  logic [16:0] rx_total_d;
  logic [16:0] rx_cnt_q;
  logic [16:0] rx_cnt_d;
  logic [16:0] rx_prev_q;
  logic [16:0] rx_prev_d;
  logic tx_act_q;
  logic tx_act_d;
  logic [15:0] resp_len_q;
  logic [15:0] tx_off_q;
  logic [15:0] tx_off_d;
  logic [8:0] tx_seg_q;
  logic [8:0] tx_seg_d;
  logic last_resp_q;
  logic [15:0] a_sw;
  logic a_calc;
  logic [16:0] hdr_total;
  logic hdr_ok;
  logic [8:0] le_eff;
  logic [15:0] rem;
  logic [31:0] rd_d;
  logic is_file;
  logic is_auth;

  assign req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr = req & i_wb_we & (i_wb_sel == 4'hF);
  assign cmd = flac_pkg::flac_cmd_t'(i_wb_dat);
  assign tlv = flac_pkg::flac_tlv_t'(tlv_q);
  assign blk = cmd.p1[7:5]; // see [RULE_23]
  // Command writes during a running computation are ignored
  assign cmd_go = wr & (i_wb_adr == `FLAC_ADR_CMD) & (auth_q != flac_pkg::flac_auth_calc);
  assign is_file = cmd_go & ((cmd.op == flac_pkg::flac_op_disable) |
                             (cmd.op == flac_pkg::flac_op_reenable));
  assign is_auth = cmd_go & ~is_file;

  // Wishbone acknowledge, one cycle after request
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_wb_ack <= 1'b0;
    else
      o_wb_ack <= req;
  end

  // Configuration registers written by software
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      acc_deact_q <= `FLAC_RST_FLAGS;
      acc_act_q <= `FLAC_RST_FLAGS;
      tgt_file_q <= 4'h0;
      tgt_dir_q <= 4'h0;
      tgt_found_q <= 1'b0;
      tlv_q <= `FLAC_RST_WORD;
    end
    else if (wr)
    begin
      if (i_wb_adr == `FLAC_ADR_ACC)
      begin
        acc_deact_q <= i_wb_dat[`FLAC_ACC_DEACT_LSB +: 16];
        acc_act_q <= i_wb_dat[`FLAC_ACC_ACT_LSB +: 16];
      end
      if (i_wb_adr == `FLAC_ADR_TGT)
      begin
        tgt_file_q <= i_wb_dat[`FLAC_TGT_FILE_LSB +: 4];
        tgt_dir_q <= i_wb_dat[`FLAC_TGT_DIR_LSB +: 4];
        tgt_found_q <= i_wb_dat[`FLAC_TGT_FOUND];
      end
      if (i_wb_adr == `FLAC_ADR_TLV)
        tlv_q <= i_wb_dat;
    end
  end

  // File command decode and checks
  always_comb
  begin
    f_sw = `FLAC_SW_OK;
    f_ok = 1'b0;
    f_idx = tgt_file_q;
    f_dir = tgt_dir_q;
    f_mode = flac_pkg::flac_sel_fid;
    if (cmd.p2 != `FLAC_P2_NONE)
      f_sw = `FLAC_SW_WRONG_P; // see [RULE_07]
    else if (cmd.p1 == `FLAC_P1_BY_FID && !cmd.data_present)
    begin
      f_mode = flac_pkg::flac_sel_current; // see [RULE_08]
      f_idx = cur_file_q;
      f_dir = cur_dir_q;
      if (!cur_valid_q)
        f_sw = `FLAC_SW_NO_EF;
    end
    else if (cmd.p1 == `FLAC_P1_PATH_ROOT)
      f_mode = flac_pkg::flac_sel_root_path; // see [RULE_06]
    else if (cmd.p1 == `FLAC_P1_PATH_DIR)
      f_mode = flac_pkg::flac_sel_dir_path; // see [RULE_06]
    else if (cmd.p1 != `FLAC_P1_BY_FID)
      f_sw = `FLAC_SW_WRONG_P; // see [RULE_10]
    if (f_sw == `FLAC_SW_OK)
    begin
      if (f_mode != flac_pkg::flac_sel_current && !tgt_found_q)
        f_sw = `FLAC_SW_NOT_FOUND;
      else if (cmd.op == flac_pkg::flac_op_disable && lcs_q[f_idx])
        f_sw = `FLAC_SW_INVALIDATED; // see [RULE_05]
      else if (cmd.op == flac_pkg::flac_op_disable && !acc_deact_q[f_idx])
        f_sw = `FLAC_SW_SECURITY; // see [RULE_02]
      else if (cmd.op == flac_pkg::flac_op_reenable && !acc_act_q[f_idx])
        f_sw = `FLAC_SW_SECURITY; // see [RULE_09]
      else
        f_ok = 1'b1;
    end
  end

  // Lifecycle flags
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      lcs_q <= `FLAC_RST_FLAGS;
    else if (is_file && f_ok)
      lcs_q[f_idx] <= (cmd.op == flac_pkg::flac_op_disable); // see [RULE_01] see [RULE_09]
  end

  // Current file pointers, untouched on failure
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cur_file_q <= 4'h0;
      cur_dir_q <= 4'h0;
      cur_valid_q <= 1'b0;
      mode_q <= flac_pkg::flac_sel_current;
    end
    else if (is_file && f_ok)
    begin
      cur_file_q <= f_idx; // see [RULE_03] see [RULE_04]
      cur_dir_q <= f_dir;
      cur_valid_q <= 1'b1;
      mode_q <= f_mode;
    end
  end

  // Function gate for other commands on a file
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      allow_q <= 1'b0;
    else if (wr && i_wb_adr == `FLAC_ADR_CHK)
      allow_q <= ~lcs_q[i_wb_dat[`FLAC_CHK_FILE_LSB +: 4]] |
                 (i_wb_dat[`FLAC_CHK_FN_LSB +: 2] == 2'(flac_pkg::flac_fn_select)) |
                 (i_wb_dat[`FLAC_CHK_FN_LSB +: 2] == 2'(flac_pkg::flac_fn_reenable)); // see [RULE_05]
  end

  // Wrapper header parse of the first data block
  always_comb
  begin
    hdr_ok = (tlv.tag == `FLAC_TAG_STRUCT) | (tlv.tag == `FLAC_TAG_PLAIN); // see [RULE_14]
    hdr_total = {9'h000, tlv.len0} + 17'h0_0002;
    if (tlv.len0 == `FLAC_LEN_LONG1)
      hdr_total = {9'h000, tlv.len1} + 17'h0_0003;
    else if (tlv.len0 == `FLAC_LEN_LONG2)
      hdr_total = {1'b0, tlv.len1, tlv.len2} + 17'h0_0004;
    else if (tlv.len0[7])
      hdr_ok = 1'b0;
  end

  assign le_eff = (cmd.lc == 8'h00) ? `FLAC_LE_MAX : {1'b0, cmd.lc};
  assign rem = resp_len_q - tx_off_d;

  // Authenticate chaining
  always_comb
  begin
    a_sw = `FLAC_SW_OK;
    a_calc = 1'b0;
    auth_d = auth_q;
    rx_act_d = rx_act_q;
    rx_total_d = rx_total_q;
    rx_cnt_d = rx_cnt_q;
    rx_prev_d = rx_prev_q;
    tx_act_d = tx_act_q;
    tx_off_d = tx_off_q;
    tx_seg_d = tx_seg_q;
    if (cmd.op == flac_pkg::flac_op_auth_even)
    begin
      if (cmd.p1 != 8'h00)
        a_sw = `FLAC_SW_WRONG_P;
      else if (cmd.lc == 8'h00)
        a_sw = `FLAC_SW_WRONG_LEN;
      else
      begin
        auth_d = flac_pkg::flac_auth_calc; // see [RULE_12]
        a_calc = 1'b1;
        rx_total_d = {9'h000, cmd.lc};
        rx_act_d = 1'b0;
        tx_act_d = 1'b0;
      end
    end
    else
    begin
      unique case (blk) // see [RULE_13]
        `FLAC_BLK_FIRST_DATA:
        begin
          if (!hdr_ok)
          begin
            a_sw = `FLAC_SW_WRONG_DATA;
            auth_d = flac_pkg::flac_auth_idle;
            rx_act_d = 1'b0;
          end
          else if (cmd.lc == 8'h00)
            a_sw = `FLAC_SW_WRONG_LEN; // see [RULE_24]
          else
          begin
            rx_act_d = 1'b1; // see [RULE_15]
            tx_act_d = 1'b0;
            rx_total_d = hdr_total;
            rx_prev_d = 17'h0_0000;
            rx_cnt_d = {9'h000, cmd.lc};
          end
        end
        `FLAC_BLK_NEXT_DATA, `FLAC_BLK_RETX_DATA:
        begin
          if (!rx_act_q || (blk == `FLAC_BLK_NEXT_DATA && auth_q != flac_pkg::flac_auth_rx))
            a_sw = `FLAC_SW_SEQUENCE; // see [RULE_25]
          else if (cmd.lc == 8'h00)
            a_sw = `FLAC_SW_WRONG_LEN;
          else if (blk == `FLAC_BLK_RETX_DATA && auth_q != flac_pkg::flac_auth_rx)
            a_sw = `FLAC_SW_DATA_DONE; // see [RULE_22]
          else if (blk == `FLAC_BLK_RETX_DATA)
            rx_cnt_d = rx_prev_q + {9'h000, cmd.lc}; // see [RULE_22]
          else
          begin
            rx_prev_d = rx_cnt_q;
            rx_cnt_d = rx_cnt_q + {9'h000, cmd.lc};
          end
        end
        `FLAC_BLK_FIRST_RESP:
        begin
          if (auth_q != flac_pkg::flac_auth_tx)
            a_sw = `FLAC_SW_SEQUENCE;
          else
          begin
            tx_act_d = 1'b1; // see [RULE_19]
            tx_off_d = 16'h0000;
          end
        end
        `FLAC_BLK_NEXT_RESP:
        begin
          if (!tx_act_q || (tx_off_q + {7'h00, tx_seg_q}) >= resp_len_q)
            a_sw = `FLAC_SW_SEQUENCE; // see [RULE_25]
          else
            tx_off_d = tx_off_q + {7'h00, tx_seg_q};
        end
        `FLAC_BLK_RETX_RESP:
        begin
          if (!tx_act_q)
            a_sw = `FLAC_SW_SEQUENCE; // see [RULE_25]
        end
        default:
          a_sw = `FLAC_SW_WRONG_P;
      endcase
      if (a_sw == `FLAC_SW_OK && !blk[0])
      begin
        if (rx_cnt_d > rx_total_d)
        begin
          a_sw = `FLAC_SW_WRONG_DATA;
          auth_d = flac_pkg::flac_auth_idle;
          rx_act_d = 1'b0;
        end
        else if (rx_cnt_d == rx_total_d)
        begin
          a_sw = `FLAC_SW_DATA_DONE; // see [RULE_18]
          auth_d = flac_pkg::flac_auth_calc;
          a_calc = 1'b1;
        end
        else
        begin
          a_sw = `FLAC_SW_DATA_MORE; // see [RULE_17]
          auth_d = flac_pkg::flac_auth_rx;
        end
      end
      else if (a_sw == `FLAC_SW_OK)
      begin
        if (blk != `FLAC_BLK_RETX_RESP)
          tx_seg_d = ({7'h00, le_eff} < rem) ? le_eff : rem[8:0];
        if (tx_off_d + {7'h00, tx_seg_d} < resp_len_q)
          a_sw = `FLAC_SW_RESP_MORE; // see [RULE_20]
        else
          a_sw = `FLAC_SW_OK; // see [RULE_21]
      end
    end
  end

  // Chaining state
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      auth_q <= flac_pkg::flac_auth_idle;
      even_q <= 1'b0;
      rx_act_q <= 1'b0;
      rx_total_q <= 17'h0_0000;
      rx_cnt_q <= 17'h0_0000;
      rx_prev_q <= 17'h0_0000;
      tx_act_q <= 1'b0;
      resp_len_q <= 16'h0000;
      tx_off_q <= 16'h0000;
      tx_seg_q <= 9'h000;
    end
    else if (is_auth)
    begin
      auth_q <= auth_d;
      even_q <= (cmd.op == flac_pkg::flac_op_auth_even);
      rx_act_q <= rx_act_d;
      rx_total_q <= rx_total_d;
      rx_cnt_q <= rx_cnt_d;
      rx_prev_q <= rx_prev_d;
      tx_act_q <= tx_act_d;
      tx_off_q <= tx_off_d;
      tx_seg_q <= tx_seg_d;
    end
    else if (auth_q == flac_pkg::flac_auth_calc && i_calc_done)
    begin
      resp_len_q <= i_calc_len;
      tx_off_q <= 16'h0000;
      tx_seg_q <= (i_calc_len > 16'(`FLAC_LE_MAX)) ? `FLAC_LE_MAX : i_calc_len[8:0];
      auth_q <= even_q ? flac_pkg::flac_auth_idle : flac_pkg::flac_auth_tx;
    end
  end

  // Engine request and challenge length
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_calc_req <= 1'b0;
      o_calc_len <= 17'h0_0000;
    end
    else
    begin
      o_calc_req <= is_auth & a_calc; // see [RULE_18]
      if (is_auth && a_calc)
        o_calc_len <= rx_total_d;
    end
  end

  // Status word of the last command
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sw_q <= `FLAC_SW_NONE;
      last_resp_q <= 1'b0;
    end
    else if (is_file)
    begin
      sw_q <= f_sw;
      last_resp_q <= 1'b0;
    end
    else if (is_auth)
    begin
      sw_q <= a_sw;
      last_resp_q <= (cmd.op == flac_pkg::flac_op_auth_odd) & blk[0];
    end
    else if (auth_q == flac_pkg::flac_auth_calc && i_calc_done && even_q)
      sw_q <= `FLAC_SW_OK;
  end

  // Read mux
  always_comb
  begin
    rd_d = `FLAC_RST_WORD;
    unique case (i_wb_adr)
      `FLAC_ADR_TGT: rd_d = {23'h00_0000, tgt_found_q, tgt_dir_q, tgt_file_q};
      `FLAC_ADR_ACC: rd_d = {acc_act_q, acc_deact_q};
      `FLAC_ADR_TLV: rd_d = tlv_q;
      `FLAC_ADR_STAT: rd_d = {auth_q == flac_pkg::flac_auth_calc, 1'b0, allow_q, 2'b00,
                              2'(mode_q), cur_valid_q, cur_dir_q, cur_file_q, sw_q};
      `FLAC_ADR_LCS: rd_d = {16'h0000, lcs_q};
      `FLAC_ADR_SEG: rd_d = {7'h00, tx_seg_q, tx_off_q};
      default: rd_d = `FLAC_RST_WORD;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_wb_dat <= `FLAC_RST_WORD;
    else if (req && !i_wb_we)
      o_wb_dat <= rd_d;
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  a_disable_flag: assert property ( // see [RULE_01]
    (is_file && f_ok && cmd.op == flac_pkg::flac_op_disable) |=> lcs_q[$past(f_idx)])
    else $error("disable did not set flag");
  a_disable_guard: assert property ( // see [RULE_02]
    (is_file && cmd.op == flac_pkg::flac_op_disable && !acc_deact_q[f_idx]) |=> $stable(lcs_q))
    else $error("disable without access changed flags");
  a_current_set: assert property ( // see [RULE_03]
    (is_file && f_ok) |=> (cur_file_q == $past(f_idx)) && (cur_dir_q == $past(f_dir)) && cur_valid_q)
    else $error("current file not updated");
  a_fail_keeps: assert property ( // see [RULE_04]
    (is_file && !f_ok) |=> $stable(cur_file_q) && $stable(cur_dir_q) && sw_q != `FLAC_SW_OK)
    else $error("failed command moved pointers");
  a_gate_other: assert property ( // see [RULE_05]
    (wr && i_wb_adr == `FLAC_ADR_CHK && lcs_q[i_wb_dat[3:0]] && i_wb_dat[5]) |=> !allow_q)
    else $error("deactivated file allowed");
  a_rx_pending: assert property ( // see [RULE_17]
    (auth_q == flac_pkg::flac_auth_rx && $changed(rx_cnt_q))
    |-> (rx_cnt_q < rx_total_q) && sw_q == `FLAC_SW_DATA_MORE)
    else $error("pending chain with wrong status");
  a_calc_status: assert property ( // see [RULE_18]
    (o_calc_req && !even_q) |-> sw_q == `FLAC_SW_DATA_DONE && auth_q == flac_pkg::flac_auth_calc)
    else $error("engine started without done status");
  a_resp_more: assert property ( // see [RULE_20]
    (last_resp_q && sw_q == `FLAC_SW_RESP_MORE) |-> (tx_off_q + {7'h00, tx_seg_q}) < resp_len_q)
    else $error("more status on last segment");
  a_resp_final: assert property ( // see [RULE_21]
    (last_resp_q && sw_q == `FLAC_SW_OK) |-> (tx_off_q + {7'h00, tx_seg_q}) == resp_len_q)
    else $error("final status before last segment");
  a_orphan_next: assert property ( // see [RULE_25]
    (is_auth && cmd.op == flac_pkg::flac_op_auth_odd && blk == `FLAC_BLK_NEXT_DATA && !rx_act_q)
    |=> sw_q == `FLAC_SW_SEQUENCE && $stable(rx_cnt_q) && $stable(auth_q))
    else $error("orphan next block accepted");

  c_chain_done: cover property (auth_q == flac_pkg::flac_auth_rx ##[1:50] o_calc_req);
  c_resp_final: cover property (last_resp_q && sw_q == `FLAC_SW_OK);
  c_file_disable: cover property (is_file && f_ok && cmd.op == flac_pkg::flac_op_disable);
  c_retx_data: cover property (is_auth && blk == `FLAC_BLK_RETX_DATA && rx_act_q);

endmodule : flac_core

`default_nettype wire

// File: testbench/flac_engine_model.sv
// Authentication engine model: answers each start pulse after a few cycles.
// Assumes the start pulse lasts one cycle and done is sampled in calc state.
`timescale 1ns/1ns
`default_nettype none

module flac_engine_model #(
  parameter logic [15:0] RESP_LEN = 16'h012C
) (
  input wire logic i_core_clk, // Clock
  input wire logic i_rst_b, // Reset, active low
  input wire logic i_req, // Start pulse
  output logic o_done, // Finished pulse
  output logic [15:0] o_len // Response length
);
  logic [3:0] cnt_q;

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      cnt_q <= 4'h0;
    else if (i_req)
      cnt_q <= 4'h5;
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
  end

  assign o_done = (cnt_q == 4'h1);
  // Length is only meaningful with done
  assign o_len = o_done ? RESP_LEN : ~RESP_LEN;
endmodule : flac_engine_model

`default_nettype wire

// File: testbench/tb_top.sv
// Bench for flac_core: file commands and chained authenticate over Wishbone.
// Assumes the engine model stands on the engine port.
`timescale 1ns/1ns
`default_nettype none
`include "flac_regs.svh"

module tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack;
  logic creq;
  logic cdone;
  logic [15:0] clen_in;
  logic [16:0] clen_out;
  int errors = 0;
  int cmp_count = 0;

  always #2 clk = ~clk;

  flac_core dut (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .i_calc_done(cdone),
    .i_calc_len(clen_in), .o_wb_dat(rdat), .o_wb_ack(ack), .o_calc_req(creq),
    .o_calc_len(clen_out)
  );

  flac_engine_model eng (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_req(creq), .o_done(cdone), .o_len(clen_in)
  );

  task automatic finish_test();
    $display("errors=%0d cmp_count=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(q & m, e);
  endtask : rd

  task automatic cmd(input logic [31:0] c, input logic [15:0] sw);
    wb(1'b1, `FLAC_ADR_CMD, c);
    rd(`FLAC_ADR_STAT, 32'h0000_FFFF, {16'h0000, sw});
  endtask : cmd

  function automatic logic [31:0] mk(input logic [1:0] op, input logic dp,
                                     input logic [7:0] lc, input logic [7:0] p1);
    return {5'h00, op, dp, lc, 8'h00, p1};
  endfunction : mk

  task automatic t_file();
    wb(1'b1, `FLAC_ADR_TGT, 32'h0000_0123);
    wb(1'b1, `FLAC_ADR_ACC, 32'h0008_0008);
    cmd(mk(2'd0, 1'b1, 8'h02, 8'h00), `FLAC_SW_OK);
    rd(`FLAC_ADR_LCS, 32'h0000_FFFF, 32'h0000_0008);
    rd(`FLAC_ADR_STAT, 32'h07FF_0000, 32'h0323_0000);
    wb(1'b1, `FLAC_ADR_CHK, 32'h0000_0023);
    rd(`FLAC_ADR_STAT, 32'h2000_0000, 32'h0000_0000);
    wb(1'b1, `FLAC_ADR_CHK, 32'h0000_0003);
    rd(`FLAC_ADR_STAT, 32'h2000_0000, 32'h2000_0000);
    cmd(mk(2'd1, 1'b1, 8'h02, 8'h08), `FLAC_SW_OK);
    rd(`FLAC_ADR_LCS, 32'h0000_FFFF, 32'h0000_0000);
    rd(`FLAC_ADR_STAT, 32'h07FF_0000, 32'h0523_0000);
    cmd(mk(2'd0, 1'b0, 8'h00, 8'h00), `FLAC_SW_OK);
    rd(`FLAC_ADR_STAT, 32'h07FF_0000, 32'h0123_0000);
    wb(1'b1, `FLAC_ADR_TGT, 32'h0000_0125);
    cmd(mk(2'd0, 1'b1, 8'h02, 8'h09), `FLAC_SW_SECURITY);
    rd(`FLAC_ADR_STAT, 32'h01FF_0000, 32'h0123_0000);
    rd(`FLAC_ADR_LCS, 32'h0000_FFFF, 32'h0000_0008);
  endtask : t_file

  task automatic t_auth();
    int n;
    // Application taken as already selected
    cmd(mk(2'd3, 1'b1, 8'h03, 8'h00), `FLAC_SW_SEQUENCE);
    wb(1'b1, `FLAC_ADR_TLV, 32'h0000_0453);
    cmd(mk(2'd3, 1'b1, 8'h03, 8'h80), `FLAC_SW_DATA_MORE);
    cmd(mk(2'd3, 1'b1, 8'h03, 8'h00), `FLAC_SW_DATA_DONE);
    chk({15'h0000, clen_out}, 32'h0000_0006);
    n = 0;
    do
    begin
      wb(1'b0, `FLAC_ADR_STAT, 32'h0000_0000);
      n++;
    end
    while (q[31] !== 1'b0 && n < 20);
    chk({31'h0000_0000, q[31]}, 32'h0000_0000);
    cmd(mk(2'd3, 1'b0, 8'h00, 8'hA0), `FLAC_SW_RESP_MORE);
    rd(`FLAC_ADR_SEG, 32'h01FF_FFFF, 32'h0100_0000);
    cmd(mk(2'd3, 1'b0, 8'h00, 8'h60), `FLAC_SW_RESP_MORE);
    rd(`FLAC_ADR_SEG, 32'h01FF_FFFF, 32'h0100_0000);
    cmd(mk(2'd3, 1'b0, 8'h2C, 8'h20), `FLAC_SW_OK);
    rd(`FLAC_ADR_SEG, 32'h01FF_FFFF, 32'h002C_0100);
    rd(8'hF0, 32'hFFFF_FFFF, 32'h0000_0000);
    // Even instruction: short plain challenge in one command
    cmd(mk(2'd2, 1'b1, 8'h10, 8'h00), `FLAC_SW_OK);
    chk({15'h0000, clen_out}, 32'h0000_0010);
    n = 0;
    do
    begin
      wb(1'b0, `FLAC_ADR_STAT, 32'h0000_0000);
      n++;
    end
    while (q[31] !== 1'b0 && n < 20);
    chk(q & 32'h8000_FFFF, 32'h0000_9000);
  endtask : t_auth

  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_file();
    t_auth();
    finish_test();
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    finish_test();
  end
endmodule : tb_top

`default_nettype wire
